// *** core/chan_pkg.sv ***
package chan_pkg;
  localparam int          ADDR_W       = 24;
  localparam int          DATA_W       = 16;
  localparam int          DMA_N        = 8;
  localparam int          IRQ_N        = 16;
  localparam int          IRQ_RANKS    = 10;
  localparam int          LOW_MB_BIT   = 20;
  localparam int          CHK_MIN_CYC  = 2;
  localparam int          SYNC_C_W     = 26;
  localparam int          SYNC_B_W     = 22;
  localparam logic [7:0]  DMA_PIN_MASK = 8'hEF;
  localparam logic [7:0]  DMA_WIDE     = 8'hE0;
  localparam logic [7:0]  DMA_NONE_N   = 8'hFF;
  localparam logic [15:0] IRQ_PIN_MASK = 16'hCEF8;
  localparam logic [3:0]  WAIT_8BIT    = 4'h4;
  localparam logic [3:0]  WAIT_16BIT   = 4'h1;
  localparam logic [3:0]  WAIT_ZERO    = 4'h0;
  localparam logic [3:0]  IRQ_ORDER [IRQ_RANKS] =
    '{4'h9, 4'hA, 4'hB, 4'hE, 4'hF, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
  localparam logic [SYNC_C_W-1:0] SYNC_C_IDLE = 26'h0000003;
  localparam logic [SYNC_B_W-1:0] SYNC_B_IDLE = 22'h3F0000;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              is_mem;
    logic              is_write;
    logic              word;
    logic              refresh;
  } cyc_req_s;

  typedef enum logic [1:0] {B_IDLE, B_ADDR, B_CMD, B_FIN} bus_st_e;
endpackage

// *** core/chan_ctrl.sv ***
`timescale 1ns/1ps
module chan_ctrl (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     ce,
  input  wire logic                     bus_clk,
  input  wire logic                     cyc_valid,
  input  wire chan_pkg::cyc_req_s       cyc_req,
  output logic                          cyc_busy_q,
  output logic                          cyc_done_q,
  output logic [chan_pkg::DATA_W-1:0]   cyc_rdata_q,
  input  wire logic [chan_pkg::DMA_N-1:0] dma_request,
  output logic [chan_pkg::DMA_N-1:0]    dma_ack_n_q,
  output logic                          dma_wide_q,
  output logic                          dma_addr_owner_q,
  input  wire logic                     tc_hit,
  output logic                          terminal_count_q,
  input  wire logic [chan_pkg::IRQ_N-1:0] int_request,
  input  wire logic                     int_ack,
  output logic                          int_valid_q,
  output logic [3:0]                    int_id_q,
  input  wire logic                     channel_check_n,
  output logic                          nmi_q,
  output logic                          channel_reset_out_q,
  input  wire logic                     channel_ready,
  input  wire logic                     zero_wait_n,
  input  wire logic                     mem_16bit_sel_n,
  input  wire logic                     io_16bit_sel_n,
  input  wire logic                     bus_master_n,
  output logic                          addr_latch_strobe_q,
  output logic [chan_pkg::ADDR_W-1:0]   sys_addr_q,
  output logic                          high_byte_enable_n_q,
  output logic                          io_read_n_q,
  output logic                          io_write_n_q,
  output logic                          mem_read_n_q,
  output logic                          mem_write_n_q,
  output logic                          low_mem_read_n_q,
  output logic                          low_mem_write_n_q,
  output logic                          ctl_oe_q,
  input  wire logic [chan_pkg::DATA_W-1:0] channel_data_in,
  output logic [chan_pkg::DATA_W-1:0]   channel_data_out_q,
  output logic                          channel_data_oe_q,
  input  wire logic                     refresh_in_n,
  output logic                          refresh_out_n_q,
  output logic                          refresh_oe_q,
  output logic                          refresh_seen_q
);
  import chan_pkg::*;

  // ---- system clock domain ----
  logic [SYNC_C_W-1:0] sc_m_q, sc_q;
  logic [DMA_N-1:0]    dreq, grant_d;
  logic [IRQ_N-1:0]    irq_s, irq_p_q, irq_rise, pend_q, irq_clr;
  logic                ck_low, mst_hi_c, irq_hit;
  logic [1:0]          ck_cnt_q;
  logic [3:0]          irq_sel;
  cyc_req_s            req_q;
  logic                go_tgl_q, dn_m_q, dn_s_q, dn_p_q, done_pls;
  logic                bdone_tgl_q;
  logic [DATA_W-1:0]   rsp_q;

  assign dreq     = sc_q[25:18] & DMA_PIN_MASK;
  assign irq_s    = sc_q[17:2];
  assign ck_low   = !sc_q[1];
  assign mst_hi_c = sc_q[0];
  assign irq_rise = irq_s & ~irq_p_q & IRQ_PIN_MASK;
  assign done_pls = dn_s_q ^ dn_p_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      sc_m_q <= SYNC_C_IDLE;
      sc_q   <= SYNC_C_IDLE;
    end else if (ce) begin
      sc_m_q <= {dma_request, int_request, channel_check_n, bus_master_n};
      sc_q   <= sc_m_q;
    end
  end

  always_ff @(posedge clk) begin
    channel_reset_out_q <= rst;
  end

  // lowest set bit wins; a grant stays until its request drops
  always_comb begin
    grant_d = ~dma_ack_n_q;
    if (grant_d == '0)
      grant_d = dreq & (~dreq + 8'h01);
    else if ((grant_d & dreq) == '0)
      grant_d = '0;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dma_ack_n_q      <= DMA_NONE_N;
      dma_wide_q       <= 1'b0;
      dma_addr_owner_q <= 1'b0;
      terminal_count_q <= 1'b0;
    end else if (ce) begin
      dma_ack_n_q      <= ~grant_d;
      dma_wide_q       <= |(grant_d & DMA_WIDE);
      // a cascade master owns the bus itself once it pulls master low
      dma_addr_owner_q <= |grant_d && mst_hi_c;
      terminal_count_q <= tc_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ck_cnt_q <= 2'h0;
      nmi_q    <= 1'b0;
    end else if (ce) begin
      ck_cnt_q <= ck_low ? (ck_cnt_q == 2'h3 ? ck_cnt_q : ck_cnt_q + 2'h1)
                         : 2'h0;
      // one pulse per assertion, shorter glitches are ignored
      nmi_q <= ck_low && ck_cnt_q == 2'(CHK_MIN_CYC - 1);
    end
  end

  always_comb begin
    irq_hit = 1'b0;
    irq_sel = 4'h0;
    for (int k = IRQ_RANKS - 1; k >= 0; k--) begin
      if (pend_q[IRQ_ORDER[k]]) begin
        irq_hit = 1'b1;
        irq_sel = IRQ_ORDER[k];
      end
    end
    irq_clr = '0;
    irq_clr[int_id_q] = int_ack && int_valid_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_p_q     <= '0;
      pend_q      <= '0;
      int_valid_q <= 1'b0;
      int_id_q    <= 4'h0;
    end else if (ce) begin
      irq_p_q     <= irq_s;
      pend_q      <= (pend_q & ~irq_clr) | irq_rise;
      int_valid_q <= irq_hit;
      int_id_q    <= irq_sel;
    end
  end

  // request word stays still while busy, so the bus side may read it
  always_ff @(posedge clk) begin
    if (rst) begin
      req_q       <= '0;
      go_tgl_q    <= 1'b0;
      cyc_busy_q  <= 1'b0;
      cyc_done_q  <= 1'b0;
      cyc_rdata_q <= '0;
      dn_m_q      <= 1'b0;
      dn_s_q      <= 1'b0;
      dn_p_q      <= 1'b0;
    end else if (ce) begin
      dn_m_q     <= bdone_tgl_q;
      dn_s_q     <= dn_m_q;
      dn_p_q     <= dn_s_q;
      cyc_done_q <= done_pls;
      if (done_pls) begin
        cyc_rdata_q <= rsp_q;
        cyc_busy_q  <= 1'b0;
      end else if (cyc_valid && !cyc_busy_q) begin
        req_q      <= cyc_req;
        go_tgl_q   <= ~go_tgl_q;
        cyc_busy_q <= 1'b1;
      end
    end
  end

  // ---- bus clock domain ----
  logic                brst_m_q, brst_q, bce_m_q, bce_q;
  logic [SYNC_B_W-1:0] sb_m_q, sb_q;
  logic                go_m_q, go_s_q, go_p_q, go_pend_q;
  logic                rdy_s, zws_s, m16_s, i16_s, mst_s, fin_q, wide_q;
  logic [3:0]          wait_q;
  bus_st_e             st_q, st_d;
  cyc_req_s            cur_q;
  logic                low_mb;

  assign rdy_s  = sb_q[21];
  assign zws_s  = !sb_q[20];
  assign m16_s  = !sb_q[19];
  assign i16_s  = !sb_q[18];
  assign mst_s  = sb_q[17];
  assign low_mb = cur_q.addr[ADDR_W-1:LOW_MB_BIT] == '0;

  // reset and enable reach this domain through two flops each
  always_ff @(posedge bus_clk) begin
    brst_m_q <= rst;
    brst_q   <= brst_m_q;
    bce_m_q  <= ce;
    bce_q    <= bce_m_q;
  end

  always_ff @(posedge bus_clk) begin
    if (brst_q) begin
      sb_m_q <= SYNC_B_IDLE;
      sb_q   <= SYNC_B_IDLE;
      go_m_q <= 1'b0;
      go_s_q <= 1'b0;
      go_p_q <= 1'b0;
    end else if (bce_q) begin
      sb_m_q <= {channel_ready, zero_wait_n, mem_16bit_sel_n,
                 io_16bit_sel_n, bus_master_n, refresh_in_n,
                 channel_data_in};
      sb_q   <= sb_m_q;
      go_m_q <= go_tgl_q;
      go_s_q <= go_m_q;
      go_p_q <= go_s_q;
    end
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      B_IDLE: if (go_pend_q && mst_s) st_d = B_ADDR;
      B_ADDR: st_d = B_CMD;
      // ready low holds the cycle; zero wait cuts it short
      B_CMD:  if (rdy_s && (zws_s || wait_q == WAIT_ZERO))
                st_d = B_FIN;
      B_FIN:  st_d = B_IDLE;
      default: st_d = B_IDLE;
    endcase
  end

  always_ff @(posedge bus_clk) begin
    if (brst_q) begin
      st_q        <= B_IDLE;
      go_pend_q   <= 1'b0;
      cur_q       <= '0;
      wait_q      <= WAIT_ZERO;
      wide_q      <= 1'b0;
      fin_q       <= 1'b0;
      rsp_q       <= '0;
      bdone_tgl_q <= 1'b0;
    end else if (bce_q) begin
      st_q  <= st_d;
      fin_q <= st_q == B_FIN;
      if (go_s_q ^ go_p_q)
        go_pend_q <= 1'b1;
      else if (st_q == B_IDLE && st_d == B_ADDR)
        go_pend_q <= 1'b0;
      if (st_q == B_IDLE)
        cur_q <= req_q;
      if (st_q == B_ADDR) begin
        wide_q <= cur_q.is_mem ? m16_s : i16_s;
        wait_q <= (cur_q.is_mem ? m16_s : i16_s) ? WAIT_16BIT
                                                  : WAIT_8BIT;
      end else if (st_q == B_CMD && rdy_s && wait_q != WAIT_ZERO)
        wait_q <= wait_q - 4'h1;
      // data sampled as the command ends is two flops deep by now
      if (fin_q) begin
        rsp_q       <= sb_q[DATA_W-1:0];
        bdone_tgl_q <= ~bdone_tgl_q;
      end
    end
  end

  always_ff @(posedge bus_clk) begin
    if (brst_q) begin
      addr_latch_strobe_q  <= 1'b0;
      sys_addr_q           <= '0;
      high_byte_enable_n_q <= 1'b1;
      io_read_n_q          <= 1'b1;
      io_write_n_q         <= 1'b1;
      ctl_oe_q             <= 1'b0;
      channel_data_out_q   <= '0;
      channel_data_oe_q    <= 1'b0;
      refresh_out_n_q      <= 1'b1;
      refresh_oe_q         <= 1'b0;
      refresh_seen_q       <= 1'b0;
    end else if (bce_q) begin
      addr_latch_strobe_q <= st_d == B_ADDR;
      if (st_q == B_IDLE && st_d == B_ADDR) begin
        sys_addr_q           <= req_q.addr;
        high_byte_enable_n_q <= !(req_q.word || req_q.addr[0]);
      end
      io_read_n_q  <= !(st_d == B_CMD && !cur_q.is_mem
                        && !cur_q.is_write);
      io_write_n_q <= !(st_d == B_CMD && !cur_q.is_mem
                        && cur_q.is_write);
      ctl_oe_q           <= mst_s;
      refresh_oe_q       <= mst_s;
      channel_data_out_q <= cur_q.wdata;
      channel_data_oe_q  <= mst_s && cur_q.is_write
                            && st_d == B_CMD;
      refresh_out_n_q    <= !(cur_q.refresh && st_q != B_IDLE
                              && st_d != B_IDLE);
      refresh_seen_q     <= !sb_q[16];
    end
  end

  // memory strobes change half a clock after the state does
  always_ff @(negedge bus_clk) begin
    if (brst_q) begin
      mem_read_n_q      <= 1'b1;
      mem_write_n_q     <= 1'b1;
      low_mem_read_n_q  <= 1'b1;
      low_mem_write_n_q <= 1'b1;
    end else if (bce_q) begin
      mem_read_n_q      <= !(st_q == B_CMD && cur_q.is_mem
                             && !cur_q.is_write);
      mem_write_n_q     <= !(st_q == B_CMD && cur_q.is_mem
                             && cur_q.is_write);
      low_mem_read_n_q  <= !(st_q == B_CMD && cur_q.is_mem
                             && !cur_q.is_write && low_mb);
      low_mem_write_n_q <= !(st_q == B_CMD && cur_q.is_mem
                             && cur_q.is_write && low_mb);
    end
  end

  // ---- checks ----
  chk_ack_single: assert property (@(posedge clk) disable iff (rst || !ce)
    $onehot0(~dma_ack_n_q)) else $error("two dma acks");
  chk_ack_lowest: assert property (@(posedge clk) disable iff (rst || !ce)
    ($past(dma_ack_n_q) == DMA_NONE_N && dma_ack_n_q != DMA_NONE_N)
    |-> (~dma_ack_n_q) == ($past(dreq) & (~$past(dreq) + 8'h01)))
    else $error("dma grant not lowest channel");
  chk_ch4_hidden: assert property (@(posedge clk) disable iff (rst || !ce)
    dma_ack_n_q[4] && (dma_wide_q == |(~dma_ack_n_q & DMA_WIDE)))
    else $error("channel width or hidden channel wrong");
  chk_nmi_held: assert property (@(posedge clk) disable iff (rst || !ce)
    nmi_q |-> $past(ck_low) && $past(ck_low, 2))
    else $error("nmi without two check cycles");
  chk_irq_latch: assert property (@(posedge clk) disable iff (rst || !ce)
    irq_rise != '0 |=> (pend_q & $past(irq_rise)) == $past(irq_rise))
    else $error("irq edge lost");
  chk_tc_pulse: assert property (@(posedge clk) disable iff (rst || !ce)
    tc_hit |=> terminal_count_q) else $error("tc pulse missing");

  sequence s_word_cmd;
    st_q == B_ADDR ##1 (st_q == B_CMD && wide_q && rdy_s && !zws_s)
    ##1 (rdy_s && !zws_s);
  endsequence
  chk_word_wait: assert property (@(posedge bus_clk)
    disable iff (brst_q || !bce_q)
    s_word_cmd |=> st_q == B_FIN)
    else $error("word cycle wait wrong");
  chk_ready_hold: assert property (@(posedge bus_clk)
    disable iff (brst_q || !bce_q)
    (st_q == B_CMD && !rdy_s) |=> st_q == B_CMD)
    else $error("cycle ended while not ready");
  chk_zero_wait: assert property (@(posedge bus_clk)
    disable iff (brst_q || !bce_q)
    (st_q == B_CMD && rdy_s && zws_s) |=> st_q == B_FIN)
    else $error("zero wait ignored");
  chk_float: assert property (@(posedge bus_clk)
    disable iff (brst_q || !bce_q)
    !mst_s |=> !ctl_oe_q && !channel_data_oe_q)
    else $error("drivers on under master");
  chk_low_mem: assert property (@(posedge bus_clk)
    disable iff (brst_q || !bce_q)
    !low_mem_read_n_q |-> !mem_read_n_q && low_mb)
    else $error("low read outside 1MB");
  chk_ale_addr: assert property (@(posedge bus_clk)
    disable iff (brst_q || !bce_q)
    addr_latch_strobe_q |=> $stable(sys_addr_q))
    else $error("address moved at latch");
endmodule

// *** verif/chan_adapter.sv ***
`timescale 1ns/1ps
module chan_adapter (
  input  wire logic        bus_clk,
  input  wire logic        io_read_n,
  input  wire logic        io_write_n,
  input  wire logic        mem_read_n,
  input  wire logic        mem_write_n,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] rdata,
  input  wire logic [4:0]  stall,
  input  wire logic        wide,
  output logic             ready,
  output logic             sel16_n,
  output logic [15:0]      data_in,
  output logic [15:0]      wcap
);
  logic       cmd;
  logic       cmd_q = 1'b0;
  logic [4:0] cnt_q = 5'h00;
  assign cmd = !(io_read_n && io_write_n && mem_read_n && mem_write_n);
  // held as a level so the synced select is stable through the address
  assign sel16_n = !wide;
  assign ready = (cnt_q == 5'h00);
  // off the bus the lines show the inverse, never a stale match
  assign data_in = (!io_read_n || !mem_read_n) ? rdata : ~rdata;
  always @(posedge bus_clk) begin
    cmd_q <= cmd;
    if (cmd && !cmd_q) cnt_q <= stall;
    else if (cnt_q != 5'h00) cnt_q <= cnt_q - 5'h01;
    if (!io_write_n || !mem_write_n) wcap <= wdata;
  end
endmodule

// *** verif/test_adapter_channel_bus_protocol.sv ***
`timescale 1ns/1ps
module test_adapter_channel_bus_protocol;
  import chan_pkg::*;
  logic        clk = 1'b0;
  logic        bus_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc_valid = 1'b0;
  cyc_req_s    cyc_req = '0;
  logic        busy, done, dwide, owner, tcount, ivalid, nmi;
  logic [15:0] rdata, dout, wcap, din;
  logic [7:0]  dma_req = 8'h00;
  logic [7:0]  ack_n;
  logic        tc_hit = 1'b0;
  logic [15:0] irq = 16'h0000;
  logic        int_ack = 1'b0;
  logic [3:0]  int_id;
  logic        chk_n = 1'b1;
  logic        ready, sel16_n, wide = 1'b0;
  logic [4:0]  stall = 5'h00;
  logic [15:0] mdata = 16'h5AC3;
  logic        ior_n, iow_n, mr_n, mw_n, lmr_n, lmw_n;
  logic [3:0]  seen = 4'h0;
  logic [15:0] io_len = 16'h0000;
  logic        master_n = 1'b1;
  logic        zws_n = 1'b1;
  logic        ctl_oe, hbe_n, rst_out;
  logic [23:0] saddr;
  int          miscompares = 0;
  int          n_tests = 0;

  always #50 clk = ~clk;
  always #24 bus_clk = ~bus_clk;
  always @(posedge bus_clk) begin
    if (cyc_valid) begin
      seen   <= 4'h0;
      io_len <= 16'h0000;
    end else begin
      seen <= seen | ~{mw_n, lmw_n, mr_n, lmr_n};
      if (!ior_n) io_len <= io_len + 16'h0001;
    end
  end

  chan_ctrl i_chan_ctrl (
    .clk(clk), .rst(rst), .ce(1'b1), .bus_clk(bus_clk),
    .cyc_valid(cyc_valid), .cyc_req(cyc_req), .cyc_busy_q(busy),
    .cyc_done_q(done), .cyc_rdata_q(rdata), .dma_request(dma_req),
    .dma_ack_n_q(ack_n), .dma_wide_q(dwide), .dma_addr_owner_q(owner),
    .tc_hit(tc_hit), .terminal_count_q(tcount), .int_request(irq),
    .int_ack(int_ack), .int_valid_q(ivalid), .int_id_q(int_id),
    .channel_check_n(chk_n), .nmi_q(nmi), .channel_reset_out_q(rst_out),
    .channel_ready(ready), .zero_wait_n(zws_n),
    .mem_16bit_sel_n(sel16_n), .io_16bit_sel_n(sel16_n),
    .bus_master_n(master_n), .addr_latch_strobe_q(), .sys_addr_q(saddr),
    .high_byte_enable_n_q(hbe_n), .io_read_n_q(ior_n),
    .io_write_n_q(iow_n),
    .mem_read_n_q(mr_n), .mem_write_n_q(mw_n), .low_mem_read_n_q(lmr_n),
    .low_mem_write_n_q(lmw_n), .ctl_oe_q(ctl_oe), .channel_data_in(din),
    .channel_data_out_q(dout), .channel_data_oe_q(),
    .refresh_in_n(1'b1), .refresh_out_n_q(), .refresh_oe_q(),
    .refresh_seen_q()
  );
  chan_adapter i_chan_adapter (
    .bus_clk(bus_clk), .io_read_n(ior_n), .io_write_n(iow_n),
    .mem_read_n(mr_n), .mem_write_n(mw_n), .wdata(dout), .rdata(mdata),
    .stall(stall), .wide(wide), .ready(ready), .sel16_n(sel16_n),
    .data_in(din), .wcap(wcap)
  );

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic hang(input string nm);
    miscompares++;
    $display("[ERR] %s expected response seen timeout", nm);
    test_done();
  endtask
  task automatic cyc(input logic [23:0] a, input logic m, w, wd);
    int i;
    cyc_req = '{a, 16'hC3A5, m, w, wd, 1'b0};
    cyc_valid = 1'b1;
    tick(1);
    cyc_valid = 1'b0;
    for (i = 0; i < 300 && done !== 1'b1; i++) tick(1);
    if (done !== 1'b1) hang("cycle done");
    tick(1);
  endtask

  task automatic test_io;
    cyc(24'h000300, 1'b0, 1'b0, 1'b0);
    chk("io8 data", 16'h5AC3, rdata);
    chk("io8 len", {12'h000, WAIT_8BIT} + 16'h1, io_len);
    chk("io8 addr", 16'h0300, saddr[15:0]);
    chk("io8 hbe", 16'h0001, {15'h0, hbe_n});
    stall = 5'h11;
    cyc(24'h000300, 1'b0, 1'b0, 1'b0);
    chk("io8 stall len", {12'h000, WAIT_8BIT} + 16'h12, io_len);
    stall = 5'h00;
    zws_n = 1'b0;
    cyc(24'h000300, 1'b0, 1'b0, 1'b0);
    chk("io zero wait len", 16'h0001, io_len);
    chk("io zero wait data", 16'h5AC3, rdata);
    zws_n = 1'b1;
    wide = 1'b1;
    cyc(24'h000302, 1'b0, 1'b0, 1'b1);
    chk("io16 len", {12'h000, WAIT_16BIT} + 16'h1, io_len);
    chk("io16 hbe", 16'h0000, {15'h0, hbe_n});
    cyc(24'h000302, 1'b0, 1'b1, 1'b1);
    chk("io write data", 16'hC3A5, wcap);
    wide = 1'b0;
    $display("test io done");
  endtask
  task automatic test_mem;
    wide = 1'b1;
    cyc(24'h0FFFFE, 1'b1, 1'b1, 1'b1);
    chk("low write strobes", 16'h000C, {12'h000, seen});
    cyc(24'h100000, 1'b1, 1'b1, 1'b1);
    chk("high write strobes", 16'h0008, {12'h000, seen});
    cyc(24'h0FFFFE, 1'b1, 1'b0, 1'b1);
    chk("low read strobes", 16'h0003, {12'h000, seen});
    chk("mem read data", 16'h5AC3, rdata);
    cyc(24'hFFFFFE, 1'b1, 1'b0, 1'b1);
    chk("high read strobes", 16'h0002, {12'h000, seen});
    wide = 1'b0;
    $display("test mem done");
  endtask
  task automatic wait_ack(input logic [7:0] e);
    int i;
    for (i = 0; i < 20 && ack_n !== e; i++) tick(1);
    chk("dma ack", {8'h00, e}, {8'h00, ack_n});
    if (ack_n !== e) test_done();
  endtask
  task automatic test_dma;
    dma_req = 8'h1A;
    wait_ack(8'hFD);
    chk("dma byte", 16'h0000, {15'h0, dwide});
    chk("dma owner", 16'h0001, {15'h0, owner});
    dma_req = 8'h00;
    wait_ack(8'hFF);
    dma_req = 8'h10;
    tick(10);
    chk("ch4 hidden", 16'h00FF, {8'h00, ack_n});
    dma_req = 8'hE0;
    wait_ack(8'hDF);
    chk("dma word", 16'h0001, {15'h0, dwide});
    dma_req = 8'h00;
    wait_ack(8'hFF);
    $display("test dma done");
  endtask
  task automatic test_master;
    int i;
    dma_req = 8'h20;
    wait_ack(8'hDF);
    master_n = 1'b0;
    cyc_req = '{24'h000300, 16'hC3A5, 1'b0, 1'b0, 1'b0, 1'b0};
    cyc_valid = 1'b1;
    tick(1);
    cyc_valid = 1'b0;
    tick(10);
    chk("master owner", 16'h0000, {15'h0, owner});
    chk("master float", 16'h0000, {15'h0, ctl_oe});
    chk("master no cycle", 16'h0000, io_len);
    master_n = 1'b1;
    for (i = 0; i < 300 && done !== 1'b1; i++) tick(1);
    if (done !== 1'b1) hang("master cycle done");
    chk("master read data", 16'h5AC3, rdata);
    chk("drivers back", 16'h0001, {15'h0, ctl_oe});
    dma_req = 8'h00;
    wait_ack(8'hFF);
    $display("test master done");
  endtask
  task automatic test_irq;
    int i;
    irq = 16'h0208;
    for (i = 0; i < 20 && ivalid !== 1'b1; i++) tick(1);
    chk("irq first", 16'h0009, {12'h000, int_id});
    int_ack = 1'b1;
    tick(1);
    int_ack = 1'b0;
    for (i = 0; i < 20 && int_id !== 4'h3; i++) tick(1);
    chk("irq second", 16'h0003, {12'h000, int_id});
    int_ack = 1'b1;
    tick(1);
    int_ack = 1'b0;
    tick(5);
    chk("irq level ignored", 16'h0000, {15'h0, ivalid});
    irq = 16'h0000;
    $display("test irq done");
  endtask
  task automatic test_pulses;
    int i;
    logic [15:0] n;
    n = 16'h0000;
    chk_n = 1'b0;
    for (i = 0; i < 10; i++) begin
      if (i == 3) chk_n = 1'b1;
      tick(1);
      n = n + {15'h0, nmi};
    end
    chk("nmi pulses", 16'h0001, n);
    n = 16'h0000;
    tc_hit = 1'b1;
    for (i = 0; i < 6; i++) begin
      tick(1);
      tc_hit = 1'b0;
      n = n + {15'h0, tcount};
    end
    chk("tc pulses", 16'h0001, n);
    $display("test pulses done");
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1;
    chk("reset drive on", 16'h0001, {15'h0, rst_out});
    rst = 1'b0;
    tick(5);
    chk("reset drive off", 16'h0000, {15'h0, rst_out});
    test_io();
    test_mem();
    test_dma();
    test_master();
    test_irq();
    test_pulses();
    test_done();
  end
endmodule
